// ===== src/capture_timer.sv
// 16-bit capture/compare timer with output pin, noise filter, partner sync
// assumes: AXI4-Lite master on ref_clk, all inputs synchronous to ref_clk
// Operation
// - immediate_edge_select select raises output without clock sync
// - single shot: output high start, low stop
// - pwm output in pwm mode, run state in single shot, else initial level
// - filter passes input after four equal samples
// - filter adds four clock cycles of delay
// - filter samples every clock, ignores prescaler
// - select 0x2 counts on partner clock or events
// - restart counter when partner restarts
// - strobe event output on each event condition
// - event acts only when capture input enabled
// - interrupt condition sets capture flag
// - irq while enable and flag both set
// - halt in power-down; standby needs run bit
// - run-in-standby ignored with partner clock
// - select 0 clock, 1 half clock, 3 reserved
// - enable bit 0 of control_a starts timer
// - initial level bit 5 of control_b
// - output enable bit 4 forces zero when off
// - three-bit field selects eight modes
// - flag cleared by write one or capture read
`timescale 1ns/10ps
`include "capture_timer_consts.svh"
module capture_timer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // axi4-lite write
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // system state
  input  wire logic        sleep_standby,
  input  wire logic        sleep_power_down,
  input  wire logic        debug_halt,
  // partner timer
  input  wire logic        partner_clk_tick,
  input  wire logic        partner_event_tick,
  input  wire logic        partner_count_on_event,
  input  wire logic        partner_restart,
  // event network
  input  wire logic        evt_in,
  output logic             evt_strobe,
  // pin and interrupt
  output logic             wave_out,
  output logic             irq
);
  logic [7:0]  ctrl_a_q, ctrl_b_q, ev_ctrl_q, int_en_q, dbg_q, temp_q;
  logic [15:0] cnt_q, compare_capture_value_q, cnt_d;
  logic        flag_q, run_q, run_d, div_q, set_flag, capture;
  capture_timer_pkg::fpw_t fpw_q, fpw_d;
  logic [3:0]  samp_q;
  logic        evt_lvl_q, evt_prev_q, raw_prev_q;
  logic        aw_have_q, w_have_q;
  logic [5:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // bus write decode
  wire       aw_hs    = awvalid & awready;
  wire       w_hs     = wvalid & wready;
  wire       wr_fire  = aw_have_q & w_have_q & ~bvalid;
  wire [3:0] wr_idx   = aw_addr_q[5:2];
  wire       wr_ok    = wr_idx <= `IDX_LAST;
  wire       wr_b0    = wr_fire & w_strb_q[0];
  wire       wr_b1    = wr_fire & w_strb_q[1];
  wire       wr_ca    = wr_b0 & (wr_idx == `IDX_CONTROL_A);
  wire       wr_cb    = wr_b0 & (wr_idx == `IDX_CONTROL_B);
  wire       wr_ev    = wr_b0 & (wr_idx == `IDX_EVENT_CTRL);
  wire       wr_ie    = wr_b0 & (wr_idx == `IDX_INT_ENABLE);
  wire       wr_fl    = wr_b0 & (wr_idx == `IDX_INT_FLAG);
  wire       wr_dbg   = wr_b0 & (wr_idx == `IDX_DEBUG);
  wire       wr_tmp   = wr_b0 & (wr_idx == `IDX_HIGH_BUF);
  wire       cnt_lo   = wr_b0 & (wr_idx == `IDX_COUNTER);
  wire       cnt_hi   = wr_b1 & (wr_idx == `IDX_COUNTER);
  wire       cmp_lo   = wr_b0 & (wr_idx == `IDX_COMPARE);
  wire       cmp_hi   = wr_b1 & (wr_idx == `IDX_COMPARE);
  wire       aw_have_d = ~wr_fire & (aw_have_q | aw_hs);
  wire       w_have_d  = ~wr_fire & (w_have_q | w_hs);
  wire       bvalid_d  = wr_fire | (bvalid & ~bready);
  wire       rd_fire   = arvalid & arready;
  wire       rvalid_d  = rd_fire | (rvalid & ~rready);
  wire [3:0] rd_idx    = araddr[5:2];

  // configuration fields
  capture_timer_pkg::mode_t mode;
  assign mode = capture_timer_pkg::mode_t'(ctrl_b_q[`CB_MODE]);
  wire [1:0] clock_source_select      = ctrl_a_q[`CA_CLOCK_SOURCE_SELECT];
  wire       sel_partner = clock_source_select == `CLK_PARTNER;
  wire       out_en      = ctrl_b_q[`CB_OUTEN];
  wire       immediate_edge_select_sel   = ctrl_b_q[`CB_IMMEDIATE_EDGE_SELECT];
  wire       edge_sel    = ev_ctrl_q[`EV_EDGE];
  wire       filt_en     = ev_ctrl_q[`EV_FILTER];
  wire       is_single   = mode == capture_timer_pkg::MODE_SINGLE;
  wire       is_pwm      = mode == capture_timer_pkg::MODE_PWM8;
  wire       is_capture_interrupt     = (mode >= capture_timer_pkg::MODE_CAPTURE) &&
                           (mode <= capture_timer_pkg::MODE_FREQ_PW);

  // sleep and debug gating; partner clock keeps its own standby rule
  wire active = ctrl_a_q[`CA_ENABLE] & ~sleep_power_down &
                (~sleep_standby | ctrl_a_q[`CA_RUN_IN_STANDBY_ENABLE] | sel_partner) &
                (~debug_halt | dbg_q[0]);
  wire partner_src = partner_count_on_event ? partner_event_tick
                                            : partner_clk_tick;
  wire tick = active & ((clock_source_select == `PERIPHERAL_CLOCK) |
                        ((clock_source_select == `PERIPHERAL_CLOCK_DIV2) & div_q) |
                        (sel_partner & partner_src));

  // noise filter runs on every clock, independent of the prescaler
  wire filt_stable = (&samp_q) | ~(|samp_q);
  wire evt_lvl_d   = filt_en ? (filt_stable ? samp_q[0] : evt_lvl_q)
                             : evt_in;
  wire ev_ok   = ev_ctrl_q[`EV_CAPTURE_EVENT_INPUT_ENABLE] & active;
  wire pos     = ev_ok & evt_lvl_q & ~evt_prev_q;
  wire neg     = ev_ok & ~evt_lvl_q & evt_prev_q;
  wire start_e = edge_sel ? neg : pos;
  wire stop_e  = edge_sel ? pos : neg;
  wire ss_trig = edge_sel ? (pos | neg) : pos;
  // unfiltered edge path gives the immediate output rise
  wire raw_trig = ev_ok & is_single & ~run_q & (evt_in ^ raw_prev_q) &
                  (edge_sel | evt_in);
  wire at_top  = cnt_q == compare_capture_value_q;
  wire [15:0] cnt_inc = cnt_q + 16'h0001;

  // per-mode counting sequence
  always_comb begin
    cnt_d    = cnt_q;
    run_d    = run_q;
    fpw_d    = fpw_q;
    set_flag = 1'b0;
    capture  = 1'b0;
    unique case (mode)
      capture_timer_pkg::MODE_PERIODIC: begin
        if (tick) begin
          cnt_d    = at_top ? `RST_WORD : cnt_inc;
          set_flag = at_top;
        end
      end
      capture_timer_pkg::MODE_TIMEOUT: begin
        if (run_q && tick) begin
          cnt_d    = cnt_inc;
          set_flag = at_top;
        end
        if (start_e) begin
          cnt_d = `RST_WORD;
          run_d = 1'b1;
        end else if (stop_e) begin
          run_d = 1'b0;
        end
      end
      capture_timer_pkg::MODE_CAPTURE: begin
        if (tick) cnt_d = cnt_inc;
        capture  = start_e;
        set_flag = start_e;
      end
      capture_timer_pkg::MODE_FREQ: begin
        if (tick) cnt_d = cnt_inc;
        if (start_e) begin
          cnt_d    = `RST_WORD;
          capture  = 1'b1;
          set_flag = 1'b1;
        end
      end
      capture_timer_pkg::MODE_PW: begin
        if (tick) cnt_d = cnt_inc;
        if (start_e) begin
          cnt_d = `RST_WORD;
        end else if (stop_e) begin
          capture  = 1'b1;
          set_flag = 1'b1;
        end
      end
      capture_timer_pkg::MODE_FREQ_PW: begin
        // a new sequence waits until the flag has been cleared
        unique case (fpw_q)
          capture_timer_pkg::FPW_IDLE: begin
            if (start_e && !flag_q) begin
              cnt_d = `RST_WORD;
              fpw_d = capture_timer_pkg::FPW_RUN;
            end
          end
          capture_timer_pkg::FPW_RUN: begin
            if (tick) cnt_d = cnt_inc;
            if (stop_e) begin
              capture = 1'b1;
              fpw_d   = capture_timer_pkg::FPW_DONE;
            end
          end
          capture_timer_pkg::FPW_DONE: begin
            if (tick) cnt_d = cnt_inc;
            if (start_e) begin
              set_flag = 1'b1;
              fpw_d    = capture_timer_pkg::FPW_IDLE;
            end
          end
          default: fpw_d = capture_timer_pkg::FPW_IDLE;
        endcase
        run_d = fpw_d != capture_timer_pkg::FPW_IDLE;
      end
      capture_timer_pkg::MODE_SINGLE: begin
        if (!run_q && ss_trig) begin
          cnt_d = `RST_WORD;
          run_d = 1'b1;
        end else if (run_q && tick) begin
          cnt_d    = at_top ? cnt_q : cnt_inc;
          run_d    = ~at_top;
          set_flag = at_top;
        end
      end
      capture_timer_pkg::MODE_PWM8: begin
        if (tick) begin
          cnt_d    = (cnt_q[7:0] == compare_capture_value_q[7:0]) ? `RST_WORD : cnt_inc;
          set_flag = cnt_q[7:0] == compare_capture_value_q[15:8];
        end
      end
    endcase
    if (ctrl_a_q[`CA_SYNC] && partner_restart && active)
      cnt_d = `RST_WORD;
    if (!ctrl_a_q[`CA_ENABLE]) begin
      run_d = 1'b0;
      fpw_d = capture_timer_pkg::FPW_IDLE;
    end
  end

  // bus writes take priority over the counter and capture paths
  wire [15:0] cnt_n  = {cnt_hi ? w_data_q[15:8] : cnt_d[15:8],
                        cnt_lo ? w_data_q[7:0]  : cnt_d[7:0]};
  wire [15:0] compare_capture_value_b = capture ? cnt_q : compare_capture_value_q;
  wire [15:0] compare_capture_value_n = {cmp_hi ? w_data_q[15:8] : compare_capture_value_b[15:8],
                        cmp_lo ? w_data_q[7:0]  : compare_capture_value_b[7:0]};
  wire flag_clr = (wr_fl & w_data_q[0]) |
                  (rd_fire & (rd_idx == `IDX_COMPARE) & is_capture_interrupt);
  wire flag_d   = set_flag | (flag_q & ~flag_clr);
  wire [7:0] int_en_d = wr_ie ? (w_data_q[7:0] & `BIT0_MASK) : int_en_q;
  wire irq_d = int_en_d[0] & flag_d;

  // output pin
  wire pwm_hi = (compare_capture_value_q[7:0] != 8'h00) & (cnt_d[7:0] < compare_capture_value_q[15:8]);
  wire wave_d = ~out_en ? 1'b0 :
                is_single ? (run_d | (immediate_edge_select_sel & raw_trig)) :
                is_pwm ? (active & pwm_hi) :
                ctrl_b_q[`CB_INIT];

  wire uses_run = is_single | (mode == capture_timer_pkg::MODE_TIMEOUT) |
                  (mode == capture_timer_pkg::MODE_FREQ_PW);
  wire run_bit  = uses_run ? run_q : active;
  // unlisted and reserved offsets read as zero
  wire [31:0] rd_word =
    (rd_idx == `IDX_CONTROL_A)  ? {24'h000000, ctrl_a_q} :
    (rd_idx == `IDX_CONTROL_B)  ? {24'h000000, ctrl_b_q} :
    (rd_idx == `IDX_EVENT_CTRL) ? {24'h000000, ev_ctrl_q} :
    (rd_idx == `IDX_INT_ENABLE) ? {24'h000000, int_en_q} :
    (rd_idx == `IDX_INT_FLAG)   ? {31'h00000000, flag_q} :
    (rd_idx == `IDX_RUN_STATE)  ? {31'h00000000, run_bit} :
    (rd_idx == `IDX_DEBUG)      ? {24'h000000, dbg_q} :
    (rd_idx == `IDX_HIGH_BUF)   ? {24'h000000, temp_q} :
    (rd_idx == `IDX_COUNTER)    ? {16'h0000, cnt_q} :
    (rd_idx == `IDX_COMPARE)    ? {16'h0000, compare_capture_value_q} : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_a_q <= `RST_BYTE;
      ctrl_b_q <= `RST_BYTE;
      ev_ctrl_q <= `RST_BYTE;
      int_en_q <= `RST_BYTE;
      dbg_q    <= `RST_BYTE;
      temp_q   <= `RST_BYTE;
      cnt_q    <= `RST_WORD;
      compare_capture_value_q   <= `RST_WORD;
      flag_q   <= 1'b0;
      run_q    <= 1'b0;
      fpw_q    <= capture_timer_pkg::FPW_IDLE;
      div_q    <= 1'b0;
    end else begin
      if (wr_ca) ctrl_a_q <= w_data_q[7:0] & `CA_MASK;
      if (wr_cb) ctrl_b_q <= w_data_q[7:0] & `CB_MASK;
      if (wr_ev) ev_ctrl_q <= w_data_q[7:0] & `EV_MASK;
      if (wr_dbg) dbg_q <= w_data_q[7:0] & `BIT0_MASK;
      if (wr_tmp) temp_q <= w_data_q[7:0];
      int_en_q <= int_en_d;
      cnt_q    <= cnt_n;
      compare_capture_value_q   <= compare_capture_value_n;
      flag_q   <= flag_d;
      run_q    <= run_d;
      fpw_q    <= fpw_d;
      div_q    <= active & ~div_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      samp_q     <= 4'h0;
      evt_lvl_q  <= 1'b0;
      evt_prev_q <= 1'b0;
      raw_prev_q <= 1'b0;
      wave_out   <= 1'b0;
      irq        <= 1'b0;
      evt_strobe <= 1'b0;
    end else begin
      samp_q     <= {samp_q[2:0], evt_in};
      evt_lvl_q  <= evt_lvl_d;
      evt_prev_q <= evt_lvl_q;
      raw_prev_q <= evt_in;
      wave_out   <= wave_d;
      irq        <= irq_d;
      evt_strobe <= set_flag;
    end
  end

  // axi4-lite handshakes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rresp     <= `RESP_OKAY;
      rdata     <= 32'h00000000;
      aw_addr_q <= 6'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready   <= ~aw_have_d & ~bvalid_d;
      wready    <= ~w_have_d & ~bvalid_d;
      bvalid    <= bvalid_d;
      arready   <= ~rvalid_d;
      rvalid    <= rvalid_d;
      if (aw_hs) aw_addr_q <= awaddr;
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) bresp <= wr_ok ? `RESP_OKAY : `RESP_DECERR;
      if (rd_fire) begin
        rdata <= rd_word;
        rresp <= (rd_idx <= `IDX_LAST) ? `RESP_OKAY : `RESP_DECERR;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_immediate_edge_select_early;
    (out_en && immediate_edge_select_sel && raw_trig) |=> wave_out;
  endproperty
  a_immediate_edge_select_early: assert property (p_immediate_edge_select_early)
    else $error("immediate_edge_select event did not raise output next cycle");

  property p_ss_start;
    (is_single && out_en && $rose(run_q)) |-> wave_out;
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("single shot start without output high");

  property p_init_level;
    (out_en && !is_single && !is_pwm)
      |=> wave_out == $past(ctrl_b_q[`CB_INIT]);
  endproperty
  a_init_level: assert property (p_init_level)
    else $error("output does not follow initial level");

  property p_filter_hold;
    (filt_en && !filt_stable) |=> $stable(evt_lvl_q);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter passed an unstable input");

  property p_filter_delay;
    (filt_en && evt_in && !evt_lvl_q) [*5] |=> evt_lvl_q;
  endproperty
  a_filter_delay: assert property (p_filter_delay)
    else $error("filter delay exceeds four cycles");

  property p_filter_clock;
    1'b1 |=> samp_q[0] == $past(evt_in);
  endproperty
  a_filter_clock: assert property (p_filter_clock)
    else $error("filter skipped a clock sample");

  property p_partner_tick;
    (sel_partner && partner_count_on_event)
      |-> tick == (active && partner_event_tick);
  endproperty
  a_partner_tick: assert property (p_partner_tick)
    else $error("partner event clocking not followed");

  property p_restart;
    (ctrl_a_q[`CA_SYNC] && partner_restart && active && !cnt_lo &&
     !cnt_hi) |=> cnt_q == 16'h0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("counter not restarted with partner");

  property p_strobe;
    set_flag |=> (evt_strobe && flag_q);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("event condition without strobe and flag");

  property p_irq;
    irq == (int_en_q[0] && flag_q);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request disagrees with enable and flag");

  property p_power_down;
    sleep_power_down |-> !tick;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("counter ticked in power down");

  property p_flag_clear;
    (flag_clr && !set_flag) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared");

  c_single_shot: cover property (is_single && out_en && $fell(wave_out));
  c_capture_irq: cover property (is_capture_interrupt && $rose(irq));
  c_pwm_wave: cover property (is_pwm && $rose(wave_out));
  c_filter_pass: cover property (filt_en && $rose(evt_lvl_q));

endmodule // capture_timer

// ===== src/capture_timer_consts.svh
// register indices, field positions, reset values and codes
// assumes: included by bare name from the capture timer sources
`ifndef CAPTURE_TIMER_CONSTS_SVH
`define CAPTURE_TIMER_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_CONTROL_A    4'h0
`define IDX_CONTROL_B    4'h1
`define IDX_EVENT_CTRL   4'h4
`define IDX_INT_ENABLE   4'h5
`define IDX_INT_FLAG     4'h6
`define IDX_RUN_STATE    4'h7
`define IDX_DEBUG        4'h8
`define IDX_HIGH_BUF     4'h9
`define IDX_COUNTER      4'hA
`define IDX_COMPARE      4'hC
`define IDX_LAST         4'hD
// control_a fields
`define CA_ENABLE        0
`define CA_CLOCK_SOURCE_SELECT        2:1
`define CA_SYNC          4
`define CA_RUN_IN_STANDBY_ENABLE      6
`define CA_MASK          8'h57
// control_b fields
`define CB_MODE          2:0
`define CB_OUTEN         4
`define CB_INIT          5
`define CB_IMMEDIATE_EDGE_SELECT         6
`define CB_MASK          8'h77
// event_control fields
`define EV_CAPTURE_EVENT_INPUT_ENABLE        0
`define EV_EDGE          4
`define EV_FILTER        6
`define EV_MASK          8'h51
`define BIT0_MASK        8'h01
// clock select codes
`define PERIPHERAL_CLOCK          2'h0
`define PERIPHERAL_CLOCK_DIV2     2'h1
`define CLK_PARTNER      2'h2
// reset values
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
// bus responses
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3
`endif

// ===== src/capture_timer_pkg.sv
// types shared by the capture timer
// assumes: nothing beyond the language
package capture_timer_pkg;
  typedef enum logic [2:0] {
    MODE_PERIODIC, MODE_TIMEOUT, MODE_CAPTURE, MODE_FREQ,
    MODE_PW, MODE_FREQ_PW, MODE_SINGLE, MODE_PWM8
  } mode_t;
  typedef enum logic [1:0] {FPW_IDLE, FPW_RUN, FPW_DONE} fpw_t;
endpackage

// ===== verif/capture_timer_tb.sv
// self-checking bench: registers, pin, events, partner clocking, sleep
// assumes: capture_timer and partner_model share one 20 MHz clock
`timescale 1ns/10ps
`include "capture_timer_consts.svh"
module capture_timer_tb;
  logic        ref_clk, srst = 1'b1;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  // answer channels stay ready, so no response is ever stalled
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic        arvalid = 1'b0, rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        stby = 1'b0, pdown = 1'b0, dbg = 1'b0, on_ev = 1'b0;
  logic        evt_in = 1'b0, rst_req = 1'b0, evt_strobe, wave_out, irq;
  logic        partner_clk_tick, partner_event_tick;
  logic        partner_count_on_event, partner_restart;
  logic [15:0] lfsr_q = 16'h0E71;
  int          n_mismatch = 0, comparisons = 0, n_strobe = 0;
  logic [3:0]  ri [6] = '{`IDX_CONTROL_A, `IDX_CONTROL_B, `IDX_EVENT_CTRL,
                          `IDX_INT_ENABLE, `IDX_DEBUG, `IDX_HIGH_BUF};
  logic [7:0]  rm [6] = '{`CA_MASK, `CB_MASK, `EV_MASK, `BIT0_MASK,
                          `BIT0_MASK, 8'hFF};
  logic [3:0]  rs [4] = '{4'h2, 4'h3, 4'hB, 4'hD};
  // control_a, then standby/power-down/debug/event flags, then divisor
  logic [15:0] rt [10] = '{16'h0101, 16'h0302, 16'h0504, 16'h0518,
                           16'h0700, 16'h0140, 16'h0180, 16'h4181,
                           16'h0584, 16'h0120};
  logic [7:0]  ec [6] = '{8'h00, 8'h40, 8'h41, 8'h01, 8'h41, 8'h41};
  int          pw [6] = '{8, 8, 2, 8, 8, 8};
  logic [31:0] pc [4] = '{32'h0307, 32'h0300, 32'h0007, 32'h0807};
  int          pe [4] = '{30, 0, 0, 80};
  logic [31:0] wm [3] = '{32'h2, 32'h4, 32'h5};

  capture_timer uut (
    .ref_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .sleep_standby(stby), .sleep_power_down(pdown), .debug_halt(dbg),
    .partner_clk_tick, .partner_event_tick, .partner_count_on_event,
    .partner_restart, .evt_in, .evt_strobe, .wave_out, .irq
  );
  partner_model partner (
    .ref_clk, .srst, .tick_div(4'h4), .on_event(on_ev),
    .restart_req(rst_req), .partner_clk_tick, .partner_event_tick,
    .partner_count_on_event, .partner_restart
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [5:0] ad(input logic [3:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic near(input logic [15:0] a, b);
    return (a + 16'h1 >= b) && (a <= b + 16'h1);
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic aw, w;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      aw = aw && (awready !== 1'b1);
      w = w && (wready !== 1'b1);
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask
  // counter advance over a fixed span; fresh count avoids a wrap
  task automatic rate(input logic [7:0] ca, output logic [15:0] dl);
    logic [15:0] c0;
    wr(ad(`IDX_COUNTER), 32'h0);
    wr(ad(`IDX_CONTROL_A), {24'h0, ca});
    rd(ad(`IDX_COUNTER));
    c0 = d[15:0];
    cyc(100);
    rd(ad(`IDX_COUNTER));
    dl = d[15:0] - c0;
    wr(ad(`IDX_CONTROL_A), 32'h0);
  endtask
  task automatic pulse(input int w, output int n);
    evt_in <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n == w)
        evt_in <= 1'b0;
    end while (irq !== 1'b1 && n < 16);
    evt_in <= 1'b0;
  endtask
  task automatic wait_pin(input logic v, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wave_out !== v && n < 100);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (evt_strobe === 1'b1)
      n_strobe++;
  initial begin
    #1000000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    results;
  end

  initial begin
    int n, n0;
    logic [15:0] d0, dl;
    logic [7:0] r;
    cyc(3);
    srst <= 1'b0;
    cyc(1);
    foreach (ri[i]) begin
      rd(ad(ri[i]));
      chk(d, 32'h0, "reset value");
      lfsr_q = lfsr(lfsr_q);
      r = lfsr_q[7:0];
      wr(ad(ri[i]), {24'h0, r});
      rd(ad(ri[i]));
      chk(d, {24'h0, r & rm[i]}, "read back");
      wr(ad(ri[i]), 32'h0);
    end
    foreach (rs[i]) begin
      wr(ad(rs[i]), 32'hFF);
      rd(ad(rs[i]));
      chk(d, 32'h0, "reserved");
      chk(resp, `RESP_OKAY, "reserved resp");
    end
    wr(ad(4'hE), 32'h1);
    chk(resp, `RESP_DECERR, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(ad(`IDX_CONTROL_B), {26'h0, i[1:0], 4'h0});
      cyc(3);
      chk(wave_out, i == 3, "pin level");
    end
    wr(ad(`IDX_CONTROL_B), 32'h0);
    wr(ad(`IDX_INT_FLAG), 32'h1);
    wr(ad(`IDX_COUNTER), 32'h0);
    wr(ad(`IDX_COMPARE), 32'h8);
    wr(ad(`IDX_INT_ENABLE), 32'h1);
    n_strobe = 0;
    wr(ad(`IDX_CONTROL_A), 32'h1);
    do @(posedge ref_clk); while (irq !== 1'b1);
    wr(ad(`IDX_CONTROL_A), 32'h0);
    chk(n_strobe > 0, 1'b1, "event strobe");
    rd(ad(`IDX_INT_FLAG));
    chk(d, 32'h1, "flag set");
    wr(ad(`IDX_INT_ENABLE), 32'h0);
    cyc(2);
    chk(irq, 1'b0, "irq masked");
    wr(ad(`IDX_INT_ENABLE), 32'h1);
    cyc(2);
    chk(irq, 1'b1, "irq unmasked");
    wr(ad(`IDX_INT_FLAG), 32'h1);
    cyc(2);
    chk(irq, 1'b0, "irq after clear");
    wr(ad(`IDX_COMPARE), 32'hFFFF);
    foreach (rt[i]) begin
      {stby, pdown, dbg, on_ev} <= rt[i][7:4];
      rate(rt[i][15:8], dl);
      if (i == 0)
        d0 = dl;
      chk(rt[i][3:0] == 4'h0 ? dl == 16'h0 : near(dl, d0 / rt[i][3:0]),
          1'b1, "count rate");
    end
    {stby, pdown, dbg, on_ev} <= 4'h0;
    chk(d0 >= 100 && d0 <= 110, 1'b1, "base rate");
    for (int i = 0; i < 2; i++) begin
      wr(ad(`IDX_COUNTER), 32'h0);
      wr(ad(`IDX_CONTROL_A), i ? 32'h11 : 32'h01);
      cyc(200);
      rst_req <= 1'b1;
      cyc(1);
      rst_req <= 1'b0;
      // the restart pulse lands one edge after the model sees the request
      cyc(2);
      rd(ad(`IDX_COUNTER));
      chk(d[15:0] < 16'h0010, i == 1, "partner restart");
    end
    wr(ad(`IDX_CONTROL_B), 32'h3);
    foreach (ec[i]) begin
      wr(ad(`IDX_CONTROL_A), i == 5 ? 32'h03 : 32'h01);
      wr(ad(`IDX_EVENT_CTRL), {24'h0, ec[i]});
      pulse(pw[i], n);
      if (i == 3)
        n0 = n;
      chk(n < 16, i > 2, "event action");
      if (i > 3)
        chk(n, n0 + 4, "filter delay");
      cyc(12);
      rd(ad(`IDX_COMPARE));
      rd(ad(`IDX_INT_FLAG));
      chk(d, 32'h0, "capture read clear");
    end
    wr(ad(`IDX_CONTROL_A), 32'h0);
    wr(ad(`IDX_CONTROL_B), 32'h17);
    foreach (pc[i]) begin
      wr(ad(`IDX_COMPARE), pc[i]);
      wr(ad(`IDX_COUNTER), 32'h0);
      wr(ad(`IDX_CONTROL_A), 32'h1);
      cyc(16);
      n = 0;
      repeat (80) begin
        @(posedge ref_clk);
        n += (wave_out === 1'b1);
      end
      chk(n, pe[i], "pwm high time");
      wr(ad(`IDX_CONTROL_A), 32'h0);
    end
    wr(ad(`IDX_EVENT_CTRL), 32'h1);
    wr(ad(`IDX_COMPARE), 32'h20);
    for (int i = 0; i < 2; i++) begin
      wr(ad(`IDX_CONTROL_B), i ? 32'h56 : 32'h16);
      // counter parked at top so enabling alone fires no pulse
      wr(ad(`IDX_COUNTER), 32'h20);
      wr(ad(`IDX_CONTROL_A), 32'h1);
      cyc(60);
      chk(wave_out, 1'b0, "shot idle");
      evt_in <= 1'b1;
      wait_pin(1'b1, n);
      chk(i ? n == 2 : n > 2, 1'b1, "shot start");
      wait_pin(1'b0, n);
      chk(n >= 31 && n <= 36, 1'b1, "shot length");
      evt_in <= 1'b0;
      wr(ad(`IDX_CONTROL_A), 32'h0);
    end
    // capture, pulse width and frequency plus width on a 20-cycle pulse
    foreach (wm[i]) begin
      wr(ad(`IDX_CONTROL_B), wm[i]);
      wr(ad(`IDX_CONTROL_A), 32'h1);
      wr(ad(`IDX_INT_FLAG), 32'h1);
      evt_in <= 1'b1;
      cyc(20);
      evt_in <= 1'b0;
      cyc(10);
      evt_in <= 1'b1;
      cyc(4);
      rd(ad(`IDX_INT_FLAG));
      chk(d, 32'h1, "capture mode flag");
      rd(ad(`IDX_COMPARE));
      if (i > 0)
        chk(near(d[15:0], 16'd20), 1'b1, "pulse width");
      rd(ad(`IDX_INT_FLAG));
      chk(d, 32'h0, "capture mode clear");
      evt_in <= 1'b0;
      wr(ad(`IDX_CONTROL_A), 32'h0);
    end
    results;
  end
endmodule // capture_timer_tb

// ===== verif/partner_model.sv
// partner timer model: prescaled ticks, event ticks, restart pulses
// assumes: one ref_clk domain; the bench sets the divider and restarts
`timescale 1ns/10ps
module partner_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // bench control
  input  wire logic [3:0] tick_div,
  input  wire logic       on_event,
  input  wire logic       restart_req,
  // toward the timer
  output logic            partner_clk_tick,
  output logic            partner_event_tick,
  output logic            partner_count_on_event,
  output logic            partner_restart
);
  logic [3:0] div_q;
  logic       half_q;
  logic       wrap;
  assign wrap = (tick_div != 4'h0) && (div_q == tick_div - 4'h1);
  assign partner_count_on_event = on_event;
  always_ff @(posedge ref_clk) begin
    if (srst || wrap)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
    if (srst)
      half_q <= 1'b0;
    else if (wrap)
      half_q <= ~half_q;
    partner_clk_tick <= wrap && !srst;
    // event clock at half the tick rate, so the two are told apart
    partner_event_tick <= wrap && half_q && on_event;
    partner_restart <= restart_req && !srst;
  end
endmodule // partner_model
